// ### port_input_gate_pkg.sv
// Shared constants for the port C/D input gate block
package port_input_gate_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int PORT_W = 8;
  localparam logic [15:0] PORT_C_INPUT_GATE_ADDR = 16'h30ba;
  localparam logic [15:0] PORT_D_INPUT_GATE_ADDR = 16'h30bb;
  localparam logic [7:0] PORT_C_INPUT_GATE_RESET = 8'h00;
  localparam logic [7:0] PORT_D_INPUT_GATE_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  localparam logic GATED_PIN_LEVEL = 1'b0;
  localparam int SYNC_STAGES = 2;
endpackage : port_input_gate_pkg

// ### pin_input_gate.sv
// Per-pin synchroniser and input gate for one port
`timescale 1ns/100ps
module pin_input_gate #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Gate enables and raw pins
  input wire logic [WIDTH-1:0] i_gate,
  input wire logic [WIDTH-1:0] i_pin,
  // Gated, synchronised pin levels
  output logic [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;

  // Disabled pins read a fixed level so a floating pin cannot toggle logic
  generate
    for (genvar n = 0; n < WIDTH; n++) begin : g_bit
      assign level_nxt[n] = i_gate[n] ? sync_r[n] : port_input_gate_pkg::GATED_PIN_LEVEL;
    end
  endgenerate

  // Two-stage synchroniser then gated output register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_r <= '0;
      sync_r <= '0;
      level_r <= '0;
    end else begin
      meta_r <= i_pin;
      sync_r <= meta_r;
      level_r <= level_nxt;
    end
  end

  assign o_level = level_r;

  // Pin reaches the second stage two edges after it is sampled
  a_sync_two_stage: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $past(i_rstn, 2) |-> sync_r == $past(i_pin, 2))
    else $error("pin synchroniser depth wrong");
endmodule : pin_input_gate

// ### port_input_enable_cd.sv
// Input-enable registers and input gating for ports C and D
//
// Operation
// - Port C gate bit n enables pin n input when 1; software reads and writes it.
// - Port C gate bit at 0 keeps that pin's input path disabled.
// - Port D gate bit n enables pin n input when 1; all bits read/write.
// - Port D gate bit at 0 keeps that pin's input path disabled.
// - Port C gate byte decodes at absolute address 30BAh.
// - Port D gate byte decodes at absolute address 30BBh.
`timescale 1ns/100ps
module port_input_enable_cd (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rstn,
  // Register port
  input wire logic [port_input_gate_pkg::ADDR_W-1:0] i_addr,
  input wire logic [port_input_gate_pkg::DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [port_input_gate_pkg::DATA_W-1:0] o_rdata,
  // Board pins
  input wire logic [port_input_gate_pkg::PORT_W-1:0] i_port_c_pin,
  input wire logic [port_input_gate_pkg::PORT_W-1:0] i_port_d_pin,
  // Gated pin levels to the core
  output logic [port_input_gate_pkg::PORT_W-1:0] o_port_c_level,
  output logic [port_input_gate_pkg::PORT_W-1:0] o_port_d_level,
  // Current gate settings
  output logic [port_input_gate_pkg::PORT_W-1:0] o_port_c_input_gate,
  output logic [port_input_gate_pkg::PORT_W-1:0] o_port_d_input_gate
);
  logic [7:0] port_c_input_gate_r;
  logic [7:0] port_d_input_gate_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  wire sel_c;
  wire sel_d;
  wire wr_c;
  wire wr_d;

  // Address decode
  assign sel_c = (i_addr == port_input_gate_pkg::PORT_C_INPUT_GATE_ADDR);
  assign sel_d = (i_addr == port_input_gate_pkg::PORT_D_INPUT_GATE_ADDR);
  assign wr_c = i_wr && sel_c;
  assign wr_d = i_wr && sel_d;

  // Read mux; unmapped addresses read zero
  assign rdata_nxt = sel_c ? port_c_input_gate_r :
                     sel_d ? port_d_input_gate_r :
                     port_input_gate_pkg::UNMAPPED_READ_VALUE;

  // Gate registers, cleared at reset so all inputs start disabled
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      port_c_input_gate_r <= port_input_gate_pkg::PORT_C_INPUT_GATE_RESET;
      port_d_input_gate_r <= port_input_gate_pkg::PORT_D_INPUT_GATE_RESET;
    end else begin
      if (wr_c) begin
        port_c_input_gate_r <= i_wdata;
      end
      if (wr_d) begin
        port_d_input_gate_r <= i_wdata;
      end
    end
  end

  // Read data stands only in the cycle after the read strobe
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_r <= '0;
    end else if (i_rd) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= '0;
    end
  end

  // Pin gating per port
  pin_input_gate #(.WIDTH(port_input_gate_pkg::PORT_W)) u_gate_c (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_gate(port_c_input_gate_r),
    .i_pin(i_port_c_pin),
    .o_level(o_port_c_level)
  );

  pin_input_gate #(.WIDTH(port_input_gate_pkg::PORT_W)) u_gate_d (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_gate(port_d_input_gate_r),
    .i_pin(i_port_d_pin),
    .o_level(o_port_d_level)
  );

  assign o_rdata = rdata_r;
  assign o_port_c_input_gate = port_c_input_gate_r;
  assign o_port_d_input_gate = port_d_input_gate_r;

  // Checks
  a_c_write_stores: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr == 16'h30ba) |=> port_c_input_gate_r == $past(i_wdata))
    else $error("port C gate write lost");
  a_d_write_stores: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr == 16'h30bb) |=> port_d_input_gate_r == $past(i_wdata))
    else $error("port D gate write lost");
  a_c_read_back: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr == 16'h30ba) |=> o_rdata == $past(port_c_input_gate_r))
    else $error("port C gate read wrong");
  a_d_read_back: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr == 16'h30bb) |=> o_rdata == $past(port_d_input_gate_r))
    else $error("port D gate read wrong");
  a_c_gated_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (port_c_input_gate_r == 8'h00)[*2] |=> o_port_c_level == 8'h00)
    else $error("port C disabled pin leaked");
  a_d_gated_low: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (port_d_input_gate_r == 8'h00)[*2] |=> o_port_d_level == 8'h00)
    else $error("port D disabled pin leaked");
  a_c_fixed_level: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_port_c_level & ~$past(port_c_input_gate_r)) == 8'h00)
    else $error("port C gated bit not fixed");
  a_other_addr_safe: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr != 16'h30ba) |=> $stable(port_c_input_gate_r))
    else $error("port C gate changed by other address");
  a_d_addr_safe: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr != 16'h30bb) |=> $stable(port_d_input_gate_r))
    else $error("port D gate changed by other address");
  a_c_idle_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !i_wr |=> $stable(port_c_input_gate_r))
    else $error("port C gate changed without write");
  a_d_idle_hold: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !i_wr |=> $stable(port_d_input_gate_r))
    else $error("port D gate changed without write");

  // Written byte comes back on a read in the next cycle
  a_c_round_trip: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr == 16'h30ba) ##1 (i_rd && i_addr == 16'h30ba)
    |=> o_rdata == $past(i_wdata, 2))
    else $error("port C gate round trip wrong");
  a_d_round_trip: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr == 16'h30bb) ##1 (i_rd && i_addr == 16'h30bb)
    |=> o_rdata == $past(i_wdata, 2))
    else $error("port D gate round trip wrong");

  // Read data is zero for other addresses and outside the answer cycle
  a_unmapped_read: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_rd && i_addr != 16'h30ba && i_addr != 16'h30bb)
    |=> o_rdata == port_input_gate_pkg::UNMAPPED_READ_VALUE)
    else $error("unmapped read not zero");
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (!i_rstn)
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside answer cycle");

  // Pin path: enabled bits follow the pin three edges later, disabled bits stay fixed
  a_d_fixed_level: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (o_port_d_level & ~$past(port_d_input_gate_r)) == 8'h00)
    else $error("port D gated bit not fixed");
  a_c_level_follows: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $past(i_rstn, 3) |->
    o_port_c_level == ($past(i_port_c_pin, 3) & $past(port_c_input_gate_r)))
    else $error("port C enabled pin not followed");
  a_d_level_follows: assert property (@(posedge i_clk) disable iff (!i_rstn)
    $past(i_rstn, 3) |->
    o_port_d_level == ($past(i_port_d_pin, 3) & $past(port_d_input_gate_r)))
    else $error("port D enabled pin not followed");
  a_c_clear_fast: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr == 16'h30ba && i_wdata == 8'h00) |=> ##1 o_port_c_level == 8'h00)
    else $error("port C clear did not gate pins");
  a_d_clear_fast: assert property (@(posedge i_clk) disable iff (!i_rstn)
    (i_wr && i_addr == 16'h30bb && i_wdata == 8'h00) |=> ##1 o_port_d_level == 8'h00)
    else $error("port D clear did not gate pins");
endmodule : port_input_enable_cd

// ### port_input_enable_cd_test.sv
// Self-checking testbench for the port C/D input gate block
`timescale 1ns/100ps
module port_input_enable_cd_test;
  logic i_clk, i_rstn, i_wr, i_rd;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, i_port_c_pin, i_port_d_pin, o_rdata;
  logic [7:0] o_port_c_level, o_port_d_level, o_port_c_input_gate, o_port_d_input_gate;
  int n_fail = 0;
  int cmp_count = 0;
  // Rows: address, write data, expected read back
  logic [31:0] rows [7] = '{32'h30ba_a5a5, 32'h30ba_0000, 32'h30bb_5a5a, 32'h30b9_ff00,
                            32'h30bc_ff00, 32'h30ba_ffff, 32'h30bb_0000};

  port_input_enable_cd DUT (.i_clk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_port_c_pin, .i_port_d_pin, .o_port_c_level, .o_port_d_level,
    .o_port_c_input_gate, .o_port_d_input_gate);

  // Clock, 8 ns period
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One write cycle, entered and left at a rising edge; keep leaves the strobe up for a next write
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input bit keep);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    if (!keep) begin
      i_wr <= 1'b0;
    end
  endtask : wr

  // One read cycle; data checked in the answer cycle only
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_rdata, e);
    @(posedge i_clk);
  endtask : rd

  task automatic settle(input int n);
    repeat (n) @(posedge i_clk);
    @(negedge i_clk);
  endtask : settle

  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude

  // Main sequence
  initial begin
    {i_rstn, i_wr, i_rd, i_addr, i_wdata} = '0;
    {i_port_c_pin, i_port_d_pin} = {8'h3c, 8'hff};
    repeat (4) @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    rd(16'h30ba, 8'h00);
    rd(16'h30bb, 8'h00);
    settle(4);
    chk(o_port_d_level, 8'h00);
    chk(o_port_c_level, 8'h00);
    chk(o_rdata, 8'h00);
    @(posedge i_clk);
    foreach (rows[k]) begin
      wr(rows[k][31:16], rows[k][15:8], 1'b0);
      rd(rows[k][31:16], rows[k][7:0]);
    end
    chk(o_port_c_input_gate, 8'hff);
    chk(o_port_d_input_gate, 8'h00);
    settle(4);
    chk(o_port_c_level, 8'h3c);
    chk(o_port_d_level, 8'h00);
    @(posedge i_clk);
    wr(16'h30ba, 8'h0f, 1'b1);
    wr(16'h30bb, 8'h81, 1'b0);
    settle(4);
    chk(o_port_c_level, 8'h0c);
    chk(o_port_d_level, 8'h81);
    // Enabled pin change reaches the level three edges later
    @(posedge i_clk);
    i_port_c_pin <= 8'h05;
    settle(2);
    chk(o_port_c_level, 8'h0c);
    settle(1);
    chk(o_port_c_level, 8'h05);
    @(posedge i_clk);
    i_rstn <= 1'b0;
    settle(2);
    chk(o_port_c_input_gate, 8'h00);
    chk(o_port_d_input_gate, 8'h00);
    chk(o_port_c_level, 8'h00);
    chk(o_port_d_level, 8'h00);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    @(posedge i_clk);
    rd(16'h30bb, 8'h00);
    conclude();
  end
endmodule : port_input_enable_cd_test
